// [dmsf_consts.vh]
// constants for the decoder mode, state and flow controller
// What this block does
// [R1] five modes by mode select; mp3 decoding is the reset default
// [R2] host does soft reset, then mode write, then run to change mode
// [R3] bypass takes audio only from converter port; volume and tone only
// [R4] adpcm decoder handles input and data request exactly like mp3
// [R5] serial bitstream bytes are written into a 256 byte input fifo
// [R6] data request drops low once buffer holds more than 252 bytes
// [R7] source stops sending within four byte times after stop request
// [R8] serial input up to 20 Mbit/s; buffer drains at stream bitrate
// [R9] source resumes before full buffer drains, about 6 ms at 320 kbit/s
// [R10] mp3 mode disables the fractional pll part; nominal audio clocks
// [R11] request polarity setting inverts the data request level
// [R12] broadcast mode gives no flow-control feedback to the source
// [R13] broadcast mode adjusts pcm clock to track incoming stream rate
// [R14] idle, init, decode states; idle after any reset until run
// [R15] idle outputs zero; clock runs only while mute is set
// [R16] play and mute changes ignored in init; applied entering decode
// [R17] init ends when first decoded samples reach the output stage
// [R18] decode play/mute table sets clock, decoding and pcm output
// [R19] sample clocks divide oversample clock; it divides the vco
// [R20] pll locks with input clock and valid stream; then clocks supplied
// [R21] reference 10, 14.31818 or 14.7456 MHz chosen by configuration
// [R22] bit gate low ignores serial data; gate changes with clock low
// [R23] serial bitstream bytes arrive most significant bit first
// [R24] any reset clears buffer pointers so data request re-asserts
`ifndef DMSF_CONSTS_VH
`define DMSF_CONSTS_VH
`define DMSF_MODE_ENC      3'h0
`define DMSF_MODE_DEC      3'h1
`define DMSF_MODE_BYPASS   3'h2
`define DMSF_MODE_MP3      3'h3
`define DMSF_MODE_BCAST    3'h4
`define DMSF_MODE_RESET    3'h3
`define DMSF_ST_IDLE       2'h0
`define DMSF_ST_INIT       2'h1
`define DMSF_ST_DECODE     2'h2
`define DMSF_FIFO_DEPTH    256
`define DMSF_FIFO_AW       8
`define DMSF_REQ_LIMIT     9'h0FC
`define DMSF_REF_10M       2'h0
`define DMSF_REF_14M318    2'h1
`define DMSF_REF_14M746    2'h2
`define DMSF_OVERSAMPLE_CLOCK_DIV_RST  8'h02
`define DMSF_FS_DIV_RST    8'h04
`define DMSF_TRIM_MAX      8'h20
`endif

// [dmsf_fifo.v]
// parameterised byte fifo with valid/ready on both sides
`timescale 1ns/100ps
module dmsf_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 256,
    parameter AW    = 8
) (
    input  wire             sys_clk,
    input  wire             resetn,
    input  wire             clear,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [AW:0]      level
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr;
    reg [AW:0]      rd_ptr;
    wire            do_wr = in_valid && in_ready;
    wire            do_rd = out_valid && out_ready;

    assign level     = wr_ptr - rd_ptr;
    assign in_ready  = (level != DEPTH[AW:0]);
    assign out_valid = (wr_ptr != rd_ptr);
    assign out_data  = mem[rd_ptr[AW-1:0]];

    // storage has no reset; pointers alone define content
    always @(posedge sys_clk) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // pointers cleared by any reset
    always @(posedge sys_clk) begin
        if (!resetn || clear) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule // dmsf_fifo

// [dmsf_ctrl.v]
// decoder mode, decoding state and input flow controller
`timescale 1ns/100ps
`include "dmsf_consts.vh"
module dmsf_ctrl (
    input  wire        sys_clk,
    input  wire        resetn,
    input  wire        soft_reset,
    input  wire        mode_write,
    input  wire [2:0]  mode_select,
    input  wire        run_cmd,
    input  wire        play,
    input  wire        mute,
    input  wire        request_polarity,
    input  wire [1:0]  ref_select,
    input  wire        stream_valid,
    input  wire [7:0]  oversample_div,
    input  wire [7:0]  sample_div,
    input  wire        serial_bitstream_in,
    input  wire        receive_serial_clock,
    input  wire        bit_gate,
    input  wire        adc_valid,
    input  wire [31:0] adc_data,
    input  wire        drain_strobe,
    input  wire        sample_ready,
    output reg         data_request,
    output reg  [7:0]  stream_byte,
    output reg         stream_byte_valid,
    output reg  [31:0] pcm_out,
    output reg         pcm_clock_run,
    output reg         decoding,
    output reg  [1:0]  decoder_state,
    output reg  [2:0]  chip_mode,
    output reg         frac_pll_enable,
    output reg         pll_locked,
    output reg         dsp_master_clock,
    output reg         oversample_clock,
    output reg         sample_clock,
    output reg         buffer_overrun,
    output reg  [8:0]  buffer_level
);
    // synchronisers for pins from the far side
    reg  [1:0] sdi_sync;
    reg  [1:0] sck_sync;
    reg  [1:0] gate_sync;
    reg        sck_last;
    reg  [7:0] shift;
    reg  [2:0] bit_cnt;
    reg  [7:0] rx_byte;
    reg        rx_valid;
    reg  [1:0] state;
    reg  [1:0] next_state;
    reg        held_play;
    reg        held_mute;
    reg        first_out;
    reg  [7:0] oversample_clock_cnt;
    reg  [7:0] fs_cnt;
    reg  [7:0] trim;
    reg        ref_ok;
    reg        drain_go;

    wire       fifo_in_ready;
    wire [7:0] fifo_out_data;
    wire       fifo_out_valid;
    wire [8:0] fifo_level;

    wire       sck_rise;
    wire       is_bypass;
    wire       is_bcast;
    wire       flow_mode;
    wire       any_reset;
    wire       eff_play;
    wire       eff_mute;
    wire       req_level;
    wire [7:0] oversample_clock_limit;

    assign any_reset = !resetn || soft_reset;
    assign sck_rise  = sck_sync[1] && !sck_last;
    assign is_bypass = (chip_mode == `DMSF_MODE_BYPASS);
    assign is_bcast  = (chip_mode == `DMSF_MODE_BCAST);

    // adpcm decoder shares mp3 flow control; bypass and encoder do not gate it
    assign flow_mode = (chip_mode == `DMSF_MODE_MP3) || (chip_mode == `DMSF_MODE_DEC); // [R4]
    // init holds the last captured play and mute
    assign eff_play  = (state == `DMSF_ST_INIT) ? held_play : play; // [R16]
    assign eff_mute  = (state == `DMSF_ST_INIT) ? held_mute : mute; // [R16]

    // two-stage synchronisers; first stage read only by second
    always @(posedge sys_clk) begin
        if (!resetn) begin
            sdi_sync  <= 2'h0;
            sck_sync  <= 2'h0;
            gate_sync <= 2'h0;
            sck_last  <= 1'b0;
        end else begin
            sdi_sync  <= {sdi_sync[0], serial_bitstream_in};
            sck_sync  <= {sck_sync[0], receive_serial_clock};
            gate_sync <= {gate_sync[0], bit_gate};
            sck_last  <= sck_sync[1];
        end
    end

    // bit deserialiser, msb first, gated by bit gate
    // oversampling limits the link to well below a quarter of sys_clk
    // partial byte lost on soft reset
    always @(posedge sys_clk) begin
        if (any_reset) begin
            shift    <= 8'h00;
            bit_cnt  <= 3'h0;
            rx_byte  <= 8'h00;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (sck_rise && gate_sync[1] && !is_bypass) begin // [R22] [R3]
                shift   <= {shift[6:0], sdi_sync[1]}; // [R23]
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    rx_byte  <= {shift[6:0], sdi_sync[1]};
                    rx_valid <= 1'b1;
                end
            end
        end
    end

    // overrun flag: byte lost on full buffer; set wins over clear
    // flagged only, not counted
    always @(posedge sys_clk) begin
        if (!resetn) begin
            buffer_overrun <= 1'b0;
        end else if (rx_valid && !fifo_in_ready) begin
            buffer_overrun <= 1'b1;
        end else if (soft_reset) begin
            buffer_overrun <= 1'b0;
        end
    end

    // input buffer; cleared on either reset
    dmsf_fifo #(
        .WIDTH (8),
        .DEPTH (`DMSF_FIFO_DEPTH),
        .AW    (`DMSF_FIFO_AW)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .clear     (soft_reset),
        .in_data   (rx_byte),
        .in_valid  (rx_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (drain_go),
        .level     (fifo_level)
    ); // [R5] [R24]

    // drain at stream rate: one byte per drain strobe, only in init or while decoding
    always @(*) begin
        drain_go = drain_strobe && fifo_out_valid && (decoding || state == `DMSF_ST_INIT); // [R8]
    end

    // data request compares fill level with 252
    // four spare bytes absorb late sends
    assign req_level = (fifo_level > `DMSF_REQ_LIMIT) ? 1'b0 : 1'b1; // [R6]

    // flow-control and byte outputs registered
    // registered so the pin never glitches
    always @(posedge sys_clk) begin
        if (!resetn) begin
            data_request      <= 1'b1;
            stream_byte       <= 8'h00;
            stream_byte_valid <= 1'b0;
            buffer_level      <= 9'h000;
        end else begin
            // broadcast gives no feedback: hold requesting level
            if (is_bcast || !flow_mode) begin // [R12]
                data_request <= ~request_polarity; // [R11]
            end else begin
                data_request <= req_level ^ request_polarity; // [R11] [R24]
            end
            stream_byte_valid <= drain_go;
            if (drain_go) begin
                stream_byte <= fifo_out_data;
            end
            buffer_level <= fifo_level;
        end
    end

    // mode register; mp3 default, written only while idle
    // codes above broadcast refused
    always @(posedge sys_clk) begin
        if (!resetn) begin
            chip_mode <= `DMSF_MODE_RESET; // [R1]
        end else if (mode_write && state == `DMSF_ST_IDLE && mode_select <= `DMSF_MODE_BCAST) begin
            chip_mode <= mode_select; // [R1] [R2]
        end
    end

    // decoding state machine
    // decode left only by reset
    always @(*) begin
        next_state = state;
        case (state)
            `DMSF_ST_IDLE: begin
                if (run_cmd) begin
                    next_state = `DMSF_ST_INIT; // [R14]
                end
            end
            `DMSF_ST_INIT: begin
                if (first_out) begin
                    next_state = `DMSF_ST_DECODE; // [R17]
                end
            end
            `DMSF_ST_DECODE: begin
                next_state = `DMSF_ST_DECODE;
            end
            default: begin
                next_state = `DMSF_ST_IDLE;
            end
        endcase
    end

    // state register and init snapshot of play and mute
    // init stays deaf to play and mute
    always @(posedge sys_clk) begin
        if (any_reset) begin
            state     <= `DMSF_ST_IDLE; // [R14]
            held_play <= 1'b0;
            held_mute <= 1'b0;
            first_out <= 1'b0;
        end else begin
            state <= next_state;
            if (state == `DMSF_ST_IDLE && run_cmd) begin
                held_play <= play;
                held_mute <= mute;
            end
            // first samples reach output: sample ready, or converter word in bypass
            first_out <= (state == `DMSF_ST_INIT) && (sample_ready || (is_bypass && adc_valid)); // [R17]
        end
    end

    // output gating per state and play/mute
    always @(posedge sys_clk) begin
        if (any_reset) begin
            pcm_out       <= 32'h00000000;
            pcm_clock_run <= resetn && mute; // idle at once [R15]
            decoding      <= 1'b0;
            decoder_state <= `DMSF_ST_IDLE;
        end else begin
            decoder_state <= state;
            case (state)
                `DMSF_ST_IDLE: begin
                    pcm_out       <= 32'h00000000; // [R15]
                    pcm_clock_run <= mute; // [R15]
                    decoding      <= 1'b0;
                end
                `DMSF_ST_INIT: begin
                    pcm_out       <= 32'h00000000;
                    pcm_clock_run <= held_mute; // [R16]
                    decoding      <= 1'b1;
                end
                `DMSF_ST_DECODE: begin
                    pcm_clock_run <= eff_play || eff_mute; // [R18]
                    decoding      <= eff_play; // [R18]
                    // bypass passes converter words; other modes pass zero here
                    if (eff_play && !eff_mute && is_bypass && adc_valid) begin
                        pcm_out <= adc_data; // [R3]
                    end else if (!eff_play || eff_mute) begin
                        pcm_out <= 32'h00000000; // [R18]
                    end
                end
                default: begin
                    pcm_out       <= 32'h00000000;
                    pcm_clock_run <= 1'b0;
                    decoding      <= 1'b0;
                end
            endcase
        end
    end

    // reference and lock: only listed reference choices are accepted
    always @(posedge sys_clk) begin
        if (!resetn) begin
            ref_ok          <= 1'b0;
            pll_locked      <= 1'b0;
            frac_pll_enable <= 1'b0;
        end else begin
            ref_ok          <= (ref_select == `DMSF_REF_10M) || (ref_select == `DMSF_REF_14M318)
                               || (ref_select == `DMSF_REF_14M746); // [R21]
            pll_locked      <= ref_ok && stream_valid; // [R20]
            frac_pll_enable <= is_bcast; // [R10] [R13]
        end
    end

    // broadcast trim nudges the divide by buffer fill; fixed at zero elsewhere
    // one step per sample clock toggle, half a sample period, while clocks run; one step every cycle while they are stopped
    always @(posedge sys_clk) begin
        if (any_reset) begin
            trim     <= 8'h00;
        end else if (is_bcast && fs_cnt == 8'h00 && oversample_clock_cnt == 8'h00) begin
            if (fifo_level > `DMSF_REQ_LIMIT && trim != 8'h00) begin
                trim <= trim - 8'h01; // [R13]
            end else if (fifo_level < 9'h010 && trim != `DMSF_TRIM_MAX) begin
                trim <= trim + 8'h01; // [R13]
            end
        end else if (!is_bcast) begin
            trim <= 8'h00; // [R10]
        end
    end

    // limit wraps past 255
    assign oversample_clock_limit = oversample_div + trim;

    // clock dividers: sys clock as vco, oversample then sample rate
    // counters restart when stopped
    always @(posedge sys_clk) begin
        if (!resetn) begin
            oversample_clock_cnt         <= 8'h00;
            fs_cnt           <= 8'h00;
            oversample_clock <= 1'b0;
            sample_clock     <= 1'b0;
            dsp_master_clock <= 1'b0;
        end else if (!pll_locked || !pcm_clock_run) begin
            oversample_clock_cnt         <= 8'h00;
            fs_cnt           <= 8'h00;
            oversample_clock <= 1'b0;
            sample_clock     <= 1'b0;
            dsp_master_clock <= 1'b0;
        end else begin
            dsp_master_clock <= ~dsp_master_clock; // [R20]
            if (oversample_clock_cnt >= oversample_clock_limit) begin
                oversample_clock_cnt         <= 8'h00;
                oversample_clock <= ~oversample_clock; // [R19]
                if (fs_cnt >= sample_div) begin
                    fs_cnt       <= 8'h00;
                    sample_clock <= ~sample_clock; // [R19]
                end else begin
                    fs_cnt <= fs_cnt + 8'h01;
                end
            end else begin
                oversample_clock_cnt <= oversample_clock_cnt + 8'h01;
            end
        end
    end
endmodule // dmsf_ctrl

// [dmsf_ctrl_sva.sv]
// assertion checker for the decoder mode, state and flow controller
`timescale 1ns/100ps
`include "dmsf_consts.vh"
module dmsf_ctrl_chk (
    input wire        sys_clk,
    input wire        resetn,
    input wire        soft_reset,
    input wire        run_cmd,
    input wire        play,
    input wire        mute,
    input wire        request_polarity,
    input wire        sample_ready,
    input wire        data_request,
    input wire [31:0] pcm_out,
    input wire        pcm_clock_run,
    input wire        decoding,
    input wire [1:0]  decoder_state,
    input wire [2:0]  chip_mode,
    input wire        frac_pll_enable,
    input wire [8:0]  buffer_level
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // modes whose fill level throttles the source
    wire fc_mode = (chip_mode == `DMSF_MODE_MP3) || (chip_mode == `DMSF_MODE_DEC);
    wire idle2 = (decoder_state == `DMSF_ST_IDLE);
    wire dec2 = (decoder_state == `DMSF_ST_DECODE);
    property p_req_level;
        fc_mode && $stable(request_polarity) |-> data_request == ((buffer_level <= `DMSF_REQ_LIMIT) ^ request_polarity);
    endproperty
    a_req_level: assert property (p_req_level) else $error("request level wrong for fill");
    property p_no_feedback;
        !fc_mode && !request_polarity |-> data_request;
    endproperty
    a_no_feedback: assert property (p_no_feedback) else $error("request dropped in free mode");
    property p_fifo_cap;
        buffer_level <= `DMSF_FIFO_DEPTH;
    endproperty
    a_fifo_cap: assert property (p_fifo_cap) else $error("fill beyond capacity");
    property p_run;
        run_cmd && !soft_reset && idle2 |-> ##2 decoder_state == `DMSF_ST_INIT;
    endproperty
    a_run: assert property (p_run) else $error("run did not enter init");
    property p_init_end;
        (decoder_state == `DMSF_ST_INIT && sample_ready && !soft_reset) ##1 !soft_reset [*2] |=> dec2;
    endproperty
    a_init_end: assert property (p_init_end) else $error("init did not end on samples");
    property p_idle_out;
        idle2 && $past(decoder_state) == `DMSF_ST_IDLE && $stable(mute) |-> pcm_clock_run == mute && pcm_out == 32'h0;
    endproperty
    a_idle_out: assert property (p_idle_out) else $error("idle output wrong");
    property p_decode_tbl;
        dec2 && $past(decoder_state) == `DMSF_ST_DECODE && $stable(play) && $stable(mute) && chip_mode != `DMSF_MODE_BYPASS
            |-> pcm_clock_run == (play | mute) && decoding == play && (pcm_out == 32'h0 || (play && !mute));
    endproperty
    a_decode_tbl: assert property (p_decode_tbl) else $error("decode table broken");
    property p_frac;
        $stable(chip_mode) && (chip_mode == `DMSF_MODE_MP3 || chip_mode == `DMSF_MODE_BCAST)
            |-> frac_pll_enable == (chip_mode == `DMSF_MODE_BCAST);
    endproperty
    a_frac: assert property (p_frac) else $error("fractional pll wrong for mode");
    property p_mode_hold;
        !idle2 |=> $stable(chip_mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed outside idle");
    property p_soft_clear;
        soft_reset |=> idle2 ##1 buffer_level == 9'h000;
    endproperty
    a_soft_clear: assert property (p_soft_clear) else $error("soft reset left state");
    property p_bypass_fill;
        chip_mode == `DMSF_MODE_BYPASS |=> buffer_level <= $past(buffer_level);
    endproperty
    a_bypass_fill: assert property (p_bypass_fill) else $error("bypass took serial bytes");
    property p_mode_range;
        chip_mode <= `DMSF_MODE_BCAST;
    endproperty
    a_mode_range: assert property (p_mode_range) else $error("illegal mode code");
endmodule // dmsf_ctrl_chk
bind dmsf_ctrl dmsf_ctrl_chk i_dmsf_ctrl_chk (.sys_clk, .resetn, .soft_reset, .run_cmd, .play, .mute,
    .request_polarity, .sample_ready, .data_request, .pcm_out, .pcm_clock_run, .decoding, .decoder_state,
    .chip_mode, .frac_pll_enable, .buffer_level);

// [dmsf_mcu_model.sv]
// behavioural microcontroller feeding the serial bitstream pins
`timescale 1ns/100ps
module dmsf_mcu_model (
    input  wire sys_clk,
    input  wire data_request,
    input  wire go_level,
    output reg  serial_bitstream_in,
    output reg  receive_serial_clock,
    output reg  bit_gate
);
    reg     ignore_req;
    integer i;
    initial begin
        serial_bitstream_in = 1'h0;
        receive_serial_clock = 1'h0;
        bit_gate = 1'h1;
        ignore_req = 1'h0;
    end
    // bit time of 8 cycles, about 15.6 Mbit/s; clock parked low between bytes
    task send_byte(input [7:0] b, input en);
        begin
            repeat (8) @(posedge sys_clk);
            // checked before every byte, so a stop costs at most the byte in flight
            while (!ignore_req && data_request !== go_level) @(posedge sys_clk);
            #1 bit_gate = en; // gate moves only while clock is low
            for (i = 7; i >= 0; i = i - 1) begin
                serial_bitstream_in = b[i]; // msb first
                repeat (4) @(posedge sys_clk);
                #1 receive_serial_clock = 1'h1;
                repeat (4) @(posedge sys_clk);
                #1 receive_serial_clock = 1'h0;
            end
            repeat (4) @(posedge sys_clk);
            // released line shows the inverse so stale data is never mistaken
            #1 serial_bitstream_in = ~b[0];
            bit_gate = 1'h1;
        end
    endtask
endmodule // dmsf_mcu_model

// [tb_decoder_mode_state_flow_ctrl.sv]
// self-checking bench for the decoder mode, state and flow controller
`timescale 1ns/100ps
`include "dmsf_consts.vh"
module tb_decoder_mode_state_flow_ctrl;
    reg         sys_clk, resetn, soft_reset, mode_write, run_cmd, play, mute;
    reg         request_polarity, stream_valid, adc_valid, drain_strobe, sample_ready;
    reg  [2:0]  mode_select;
    reg  [1:0]  ref_select;
    reg  [7:0]  oversample_div, sample_div;
    reg  [31:0] adc_data;
    wire        serial_bitstream_in, receive_serial_clock, bit_gate, data_request, stream_byte_valid;
    wire        pcm_clock_run, decoding, frac_pll_enable, pll_locked, dsp_master_clock;
    wire        oversample_clock, sample_clock, buffer_overrun;
    wire [7:0]  stream_byte;
    wire [31:0] pcm_out;
    wire [1:0]  decoder_state;
    wire [2:0]  chip_mode;
    wire [8:0]  buffer_level;
    reg  [2:0]  clk_last;
    integer     n_fail, checks_done, cycles, k, n_tog;

    dmsf_ctrl i_dmsf_ctrl (.sys_clk, .resetn, .soft_reset, .mode_write, .mode_select, .run_cmd, .play, .mute,
        .request_polarity, .ref_select, .stream_valid, .oversample_div, .sample_div, .serial_bitstream_in,
        .receive_serial_clock, .bit_gate, .adc_valid, .adc_data, .drain_strobe, .sample_ready, .data_request,
        .stream_byte, .stream_byte_valid, .pcm_out, .pcm_clock_run, .decoding, .decoder_state, .chip_mode,
        .frac_pll_enable, .pll_locked, .dsp_master_clock, .oversample_clock, .sample_clock, .buffer_overrun,
        .buffer_level);
    dmsf_mcu_model i_dmsf_mcu_model (.sys_clk, .data_request, .go_level(~request_polarity), .serial_bitstream_in,
        .receive_serial_clock, .bit_gate);

    initial begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end
    // hang guard above the longest fill
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 60000) begin
            n_fail = n_fail + 1;
            final_report;
        end
    end
    task final_report;
        begin
            if (n_fail == 0 && checks_done > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge sys_clk);
            #1;
        end
    endtask
    // soft reset, then mode write, then settle; one idle cycle between steps
    task change_mode(input [2:0] m);
        begin
            soft_reset = 1'h1;
            tick(1);
            soft_reset = 1'h0;
            tick(1);
            mode_select = m;
            mode_write = 1'h1;
            tick(1);
            mode_write = 1'h0;
            tick(2);
        end
    endtask
    task start(input p, input m);
        begin
            play = p;
            mute = m;
            run_cmd = 1'h1;
            tick(1);
            run_cmd = 1'h0;
            mute = !m; // ignored in init
            tick(2);
            chk({decoder_state, pcm_clock_run}, {`DMSF_ST_INIT, m});
            mute = m;
            sample_ready = 1'h1;
            tick(1);
            sample_ready = 1'h0;
            tick(4);
            chk(decoder_state, `DMSF_ST_DECODE);
        end
    endtask
    task send(input [7:0] b, input en);
        begin
            i_dmsf_mcu_model.send_byte(b, en);
            tick(10);
        end
    endtask

    initial begin
        {resetn, soft_reset, mode_write, run_cmd, play, mute, request_polarity} = 7'h00;
        {adc_valid, drain_strobe, sample_ready, mode_select, adc_data} = 38'h0;
        stream_valid = 1'h1;
        ref_select = 2'h3;
        oversample_div = 8'h01;
        sample_div = 8'h01;
        n_fail = 0;
        checks_done = 0;
        cycles = 0;
        tick(3);
        resetn = 1'h1;
        tick(1);
        chk(chip_mode, `DMSF_MODE_MP3);
        chk({decoder_state, pcm_clock_run, frac_pll_enable, data_request}, 5'h01);
        mute = 1'h1;
        tick(2);
        chk(pcm_clock_run, 1'h1);
        mute = 1'h0;
        chk(pll_locked, 1'h0);
        ref_select = 2'h0;
        for (k = 0; k < 2000 && pll_locked !== 1'h1; k = k + 1) tick(1);
        chk(pll_locked, 1'h1);
        for (k = 0; k < 6; k = k + 1) begin
            change_mode(k[2:0]);
            chk(chip_mode, (k < 5) ? k : `DMSF_MODE_BCAST);
        end
        chk(frac_pll_enable, 1'h1);
        change_mode(`DMSF_MODE_MP3);
        send(8'hC5, 1'h1);
        chk(buffer_level, 9'h001);
        send(8'h3C, 1'h0);
        chk(buffer_level, 9'h001);
        start(1'h1, 1'h0);
        drain_strobe = 1'h1;
        tick(1);
        drain_strobe = 1'h0;
        for (k = 0; k < 20 && stream_byte_valid !== 1'h1; k = k + 1) tick(1);
        chk(stream_byte, 8'hC5);
        for (k = 0; k < 4; k = k + 1) begin
            play = k[1];
            mute = k[0];
            tick(3);
            chk({pcm_clock_run, decoding}, {k[1] | k[0], k[1]});
            if (k != 2) chk(pcm_out, 32'h0);
        end
        n_tog = 0;
        for (k = 0; k < 16; k = k + 1) begin
            clk_last = {dsp_master_clock, oversample_clock, sample_clock};
            tick(1);
            clk_last = clk_last ^ {dsp_master_clock, oversample_clock, sample_clock};
            n_tog = n_tog + 256 * clk_last[2] + 16 * clk_last[1] + clk_last[0];
        end
        chk(n_tog, 32'h1084);
        mode_select = `DMSF_MODE_ENC;
        mode_write = 1'h1;
        tick(1);
        mode_write = 1'h0;
        tick(2);
        chk(chip_mode, `DMSF_MODE_MP3);
        change_mode(`DMSF_MODE_MP3);
        chk(decoder_state, `DMSF_ST_IDLE);
        for (k = 1; k <= 252; k = k + 1) i_dmsf_mcu_model.send_byte(k[7:0], 1'h1);
        tick(10);
        chk({buffer_level, data_request}, {9'h0FC, 1'h1});
        send(8'hFD, 1'h1);
        chk({buffer_level, data_request}, {9'h0FD, 1'h0});
        request_polarity = 1'h1;
        tick(2);
        chk(data_request, 1'h1);
        i_dmsf_mcu_model.ignore_req = 1'h1;
        for (k = 0; k < 4; k = k + 1) send(8'hC3, 1'h1);
        chk({buffer_level, buffer_overrun}, {9'h100, 1'h1});
        i_dmsf_mcu_model.ignore_req = 1'h0;
        request_polarity = 1'h0;
        change_mode(`DMSF_MODE_DEC);
        chk({buffer_level, data_request}, {9'h000, 1'h1});
        change_mode(`DMSF_MODE_BYPASS);
        send(8'h5A, 1'h1);
        chk(buffer_level, 9'h000);
        start(1'h1, 1'h0);
        adc_data = 32'h12345678;
        adc_valid = 1'h1;
        tick(3);
        chk(pcm_out, 32'h12345678);
        adc_valid = 1'h0;
        resetn = 1'h0;
        tick(1);
        resetn = 1'h1;
        tick(1);
        chk({chip_mode, decoder_state, buffer_overrun}, {`DMSF_MODE_MP3, `DMSF_ST_IDLE, 1'h0});
        final_report;
    end
endmodule // tb_decoder_mode_state_flow_ctrl
